// [verilog/gpio_port_pkg.sv]
// shared constants, types and helpers of the sixteen-line port
`default_nettype none

package gpio_port_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned LINES = 16;      // port lines
  localparam int unsigned WORD_W = 32;     // register width
  localparam int unsigned OFFS_W = 12;     // offset bits decoded

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_DIRECTION = 12'hc00;
  localparam logic [11:0] OFF_OPEN_DRAIN = 12'hc04;
  localparam logic [11:0] OFF_PIN_DATA = 12'hc08;
  localparam logic [11:0] OFF_EVENTS = 12'hc0c;
  localparam logic [11:0] OFF_IRQ_MASK = 12'hc10;
  localparam logic [11:0] OFF_EDGE_SELECT = 12'hc14;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LINES_RESET = 16'h0000;   // every config field cleared
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // unmapped and reserved reads
  localparam logic [15:0] EVENTS_RESET = 16'h0000;  // events start clear

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic HRESP_OKAY = 1'b0;

  // bus phase tracker
  typedef enum logic [1:0] {
    BUS_IDLE      = 2'b00,
    BUS_WRITE     = 2'b01,
    BUS_READ_WAIT = 2'b10,
    BUS_READ_DONE = 2'b11
  } bus_state_t;

  // software configuration of all lines, travels as one bundle
  typedef struct packed {
    logic [15:0] direction;   // 1 output, 0 input
    logic [15:0] open_drain;  // 1 open drain when output
    logic [15:0] pin_data;    // latched output value
    logic [15:0] irq_mask;    // 1 enables the line's request
    logic [15:0] edge_select; // 1 falling only, 0 any change
  } port_cfg_t;

  // line i sits in word bit 31-i; low half reads zero
  function automatic logic [31:0] lines_to_word(input logic [15:0] v);
    logic [31:0] w;
    w = WORD_ZERO;
    for (int i = 0; i < 16; i++) begin
      w[31-i] = v[i];
    end
    return w;
  endfunction

  // picks line bits out of a word; low half ignored
  function automatic logic [15:0] word_to_lines(input logic [31:0] w);
    logic [15:0] v;
    v = LINES_RESET;
    for (int i = 0; i < 16; i++) begin
      v[i] = w[31-i];
    end
    return v;
  endfunction

endpackage : gpio_port_pkg

`default_nettype wire

// [verilog/line_sync_edge.sv]
// two-stage synchroniser and change detector for the port pins
`default_nettype none

module line_sync_edge
  import gpio_port_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised results
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] changed,
  output logic [WIDTH-1:0] fell
);

  // ----------------------------------------------------------------
  // per-line synchroniser
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta; // first stage, read only by level
  logic [WIDTH-1:0] prev; // previous synchronised sample

  // ----------------------------------------------------------------
  // warm-up after reset
  // ----------------------------------------------------------------
  // prev holds a real pin sample only from the third edge after reset;
  // before that a pin idling high would look like a change, so changes
  // inside those first edges are not reported
  logic [1:0] warm; // edges seen since reset, saturating
  wire armed = (warm == 2'h3); // successive samples are both real

  // counts the first edges after reset, then stays put
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm <= 2'h0;
    end else if (!armed) begin
      warm <= warm + 2'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_line
      // two flops, then a third holding the older sample
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta[g] <= 1'b0;
          level[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= pin_in[g];
          level[g] <= meta[g];
          prev[g] <= level[g];
        end
      end
      // successive synchronised samples compared
      assign changed[g] = (level[g] ^ prev[g]) & armed;
      assign fell[g] = prev[g] & ~level[g] & armed;
    end
  endgenerate

endmodule : line_sync_edge

`default_nettype wire

// [verilog/gpio_port.sv]
// sixteen-line port with change events, AHB-Lite registers
// Operation
// - direction bit 1 output, 0 input
// - reset makes lines inputs, config zero
// - bits 0..15 big-endian map to pins
// - open drain drives low, else released
// - open drain ignored on input lines
// - data write latched, driven when output
// - data read returns pin level always
// - event bits cleared only by one
// - events set even when masked
// - request when any unmasked event set
// - mask 1 enables, 0 disables line
// - edge bit 0 any, 1 falling
// - input lines generate change events
// - unmapped reads zero, writes ignored
// - registers 32 bit word aligned
// - asynchronous pins sampled safely
`default_nettype none

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  // request to the interrupt controller
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  port_cfg_t cfg;              // software configuration
  port_cfg_t next_cfg;         // its next value
  logic [15:0] events;         // sticky change events
  logic [15:0] next_events;
  bus_state_t state;           // bus phase
  bus_state_t next_state;
  logic [11:0] addr;           // offset held from address phase
  logic [31:0] next_rdata;     // read word chosen

  // synchroniser outputs
  logic [15:0] level;          // synchronised pin level
  logic [15:0] changed;        // level differs from previous
  logic [15:0] fell;           // high to low seen

  // ----------------------------------------------------------------
  // pin synchroniser and change detector
  // ----------------------------------------------------------------
  line_sync_edge #(
    .WIDTH(LINES)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(pin_in),
    .level(level),
    .changed(changed),
    .fell(fell)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // transfer taken when selected, non-idle and bus ready
  wire accept = hsel & hready & htrans[1];
  // data phase of a write
  wire wr_phase = (state == BUS_WRITE);
  // offset of the address phase
  wire [11:0] req_offs = haddr[OFFS_W-1:0];
  // register hits during the write data phase
  wire wr_dir = wr_phase && (addr == OFF_DIRECTION);
  wire wr_od = wr_phase && (addr == OFF_OPEN_DRAIN);
  wire wr_dat = wr_phase && (addr == OFF_PIN_DATA);
  wire wr_evt = wr_phase && (addr == OFF_EVENTS);
  wire wr_msk = wr_phase && (addr == OFF_IRQ_MASK);
  wire wr_edge = wr_phase && (addr == OFF_EDGE_SELECT);
  // only the upper half of the word carries lines
  wire [15:0] wr_lines = word_to_lines(hwdata);
  // whether the held offset names a register
  wire mapped = (addr == OFF_DIRECTION) || (addr == OFF_OPEN_DRAIN) ||
                (addr == OFF_PIN_DATA) || (addr == OFF_EVENTS) ||
                (addr == OFF_IRQ_MASK) || (addr == OFF_EDGE_SELECT);

  // ----------------------------------------------------------------
  // bus phase sequencing
  // ----------------------------------------------------------------
  // reads wait one cycle so that a write just before is visible
  always_comb begin
    next_state = state;
    case (state)
      BUS_READ_WAIT: begin
        next_state = BUS_READ_DONE;
      end
      default: begin
        // idle, write and read done phases may take a new request
        if (accept) begin
          next_state = hwrite ? BUS_WRITE : BUS_READ_WAIT;
        end else begin
          next_state = BUS_IDLE;
        end
      end
    endcase
  end

  // phase register and held offset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= BUS_IDLE;
      addr <= 12'h000;
    end else begin
      state <= next_state;
      if (accept) begin
        addr <= req_offs;
      end
    end
  end

  // stall only in the read wait cycle; always an okay response
  assign hreadyout = (state != BUS_READ_WAIT);
  assign hresp = HRESP_OKAY;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    if (addr == OFF_DIRECTION) begin
      next_rdata = lines_to_word(cfg.direction);
    end else if (addr == OFF_OPEN_DRAIN) begin
      next_rdata = lines_to_word(cfg.open_drain);
    end else if (addr == OFF_PIN_DATA) begin
      next_rdata = lines_to_word(level);
    end else if (addr == OFF_EVENTS) begin
      next_rdata = lines_to_word(events);
    end else if (addr == OFF_IRQ_MASK) begin
      next_rdata = lines_to_word(cfg.irq_mask);
    end else if (addr == OFF_EDGE_SELECT) begin
      next_rdata = lines_to_word(cfg.edge_select);
    end else begin
      next_rdata = WORD_ZERO;
    end
  end

  // read data loaded in the wait cycle, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= WORD_ZERO;
    end else if (state == BUS_READ_WAIT) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // each field takes the line bits of a write to its offset
  always_comb begin
    next_cfg = cfg;
    if (wr_dir) begin
      next_cfg.direction = wr_lines;
    end
    if (wr_od) begin
      next_cfg.open_drain = wr_lines;
    end
    if (wr_dat) begin
      next_cfg.pin_data = wr_lines;
    end
    if (wr_msk) begin
      next_cfg.irq_mask = wr_lines;
    end
    if (wr_edge) begin
      next_cfg.edge_select = wr_lines;
    end
  end

  // all fields clear on reset, so every line starts as an input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= '{default: LINES_RESET};
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // change events
  // ----------------------------------------------------------------
  // qualifying change per line, only on inputs
  wire [15:0] hit_lines = (cfg.edge_select & fell) | (~cfg.edge_select & changed);
  wire [15:0] set_lines = hit_lines & ~cfg.direction;
  // ones written to the event offset clear
  wire [15:0] clear_lines = wr_evt ? wr_lines : LINES_RESET;

  // a set arriving with its clear wins; mask plays no part
  assign next_events = (events & ~clear_lines) | set_lines;

  // sticky event bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events <= EVENTS_RESET;
    end else begin
      events <= next_events;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // any unmasked event raises the single request
  wire irq_any = |(events & cfg.irq_mask);

  // request registered, one cycle behind the events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_any;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // drive only outputs; open drain releases a high value
  wire [15:0] next_oe = cfg.direction & (~cfg.open_drain | ~cfg.pin_data);

  // latched value always present; enable decides if it reaches the pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= LINES_RESET;
      pin_oe <= LINES_RESET;
    end else begin
      pin_out <= cfg.pin_data;
      pin_oe <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // a read stalls exactly one cycle then completes
  a_read_wait_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout
  ) else $error("read did not complete after one wait");

  // a direction write lands in the following cycle
  a_dir_write_lands: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_dir |=> (cfg.direction == word_to_lines($past(hwdata)))
  ) else $error("direction write not stored");

  // an input line is never driven
  a_input_undriven: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 ((pin_oe & ~$past(cfg.direction)) == LINES_RESET)
  ) else $error("input line driven");

  // an open drain output never drives high
  a_od_never_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 ((pin_oe & pin_out & $past(cfg.open_drain)) == LINES_RESET)
  ) else $error("open drain line driven high");

  // a push-pull output always has its drive enable set
  a_pushpull_drives: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 ((pin_oe & $past(cfg.direction & ~cfg.open_drain)) == $past(cfg.direction & ~cfg.open_drain))
  ) else $error("push-pull output not driven");

  // event bits fall only where a one was written
  a_event_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 (($past(events) & ~events & ~$past(clear_lines)) == LINES_RESET)
  ) else $error("event bit lost without clear");

  // a detected change sets its bit whatever the mask
  a_masked_still_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (set_lines != LINES_RESET) |=> ((events & $past(set_lines)) == $past(set_lines))
  ) else $error("event not recorded");

  // request follows unmasked events by one cycle
  a_irq_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_any |=> irq
  ) else $error("request missing");

  // masked events alone never raise the request
  a_mask_blocks: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((events & cfg.irq_mask) == LINES_RESET) |=> !irq
  ) else $error("request with no unmasked event");

  // falling-only lines ignore a rising change
  a_fall_only: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((set_lines & cfg.edge_select & level) == LINES_RESET)
  ) else $error("rise counted on falling-only line");

  // output lines make no events
  a_output_no_event: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ((set_lines & cfg.direction) == LINES_RESET)
  ) else $error("event on output line");

  // unmapped offsets read zero
  a_unmapped_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == BUS_READ_WAIT && !mapped) |=> (hrdata == WORD_ZERO)
  ) else $error("unmapped read not zero");

  // the unused low half always reads zero
  a_low_half_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (hrdata[15:0] == 16'h0000)
  ) else $error("unused bits not zero");

  // data reads show the synchronised pin level
  a_data_reads_pins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == BUS_READ_WAIT && addr == OFF_PIN_DATA) |=> (hrdata == lines_to_word($past(level)))
  ) else $error("data read not pin level");

endmodule : gpio_port

`default_nettype wire

// [bench/pin_board.sv]
// board model that drives, releases and pulls up the sixteen port pins
`default_nettype none

module pin_board (
  // device side of the pins
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // board drivers
  input wire logic [15:0] ext_val,
  input wire logic [15:0] ext_en,
  // resolved pin level
  output logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  // device wins when it drives, then the board, else the pull-up
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule // pin_board

`default_nettype wire

// [bench/test_gpio_port.sv]
// self-checking bench for the sixteen-line port
`default_nettype none

module test_gpio_port
  import gpio_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] ext_val; // board drive values
  logic [15:0] ext_en; // board drive enables
  logic irq;
  int num_errors;
  int n_checks;

  // ----------------------------------------------------------------
  // design and board
  // ----------------------------------------------------------------
  gpio_port u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq)
  );

  pin_board u_board (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in)
  );

  // free-running 50 ns clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // line i lands in word bit 31-i
  function automatic logic [31:0] wd(input logic [15:0] v);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      r[31-i] = v[i];
    end
    return r;
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // waits for hready high at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      $display("BAD t=%0t bus hang", $time);
    end
  endtask

  // single word write: address phase, then data phase
  task automatic bus_write(input logic [11:0] o, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, o};
    hwrite <= 1'b1;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask

  // single word read and compare
  task automatic rchk(input logic [11:0] o, input logic [31:0] exp, input string what);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, o};
    hwrite <= 1'b0;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    wait_ready();
    chk(hrdata, exp, what);
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    $display("BAD t=%0t watchdog", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] offs [6];
    offs = '{OFF_DIRECTION, OFF_OPEN_DRAIN, OFF_PIN_DATA, OFF_EVENTS, OFF_IRQ_MASK, OFF_EDGE_SELECT};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    ext_val = 16'h0000;
    ext_en = 16'hffff;
    num_errors = 0;
    n_checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // every register clear, every line an input
    for (int k = 0; k < 6; k++) begin
      rchk(offs[k], 32'h0000_0000, "reset value");
    end
    chk({16'h0000, pin_oe}, 32'h0000_0000, "reset drive");
    $display("reset test done");
    // plain config words keep the line half only
    for (int k = 0; k < 6; k++) begin
      if (k == 2 || k == 3) continue;
      bus_write(offs[k], 32'ha5c3_ffff);
      rchk(offs[k], 32'ha5c3_0000, "config readback");
      bus_write(offs[k], 32'h0000_0000);
    end
    bus_write(12'hc18, 32'hffff_ffff);
    rchk(12'hc18, 32'h0000_0000, "unmapped read");
    rchk(12'h000, 32'h0000_0000, "unmapped low");
    $display("register test done");
    // lines 12-15 outputs, 13 and 15 open drain high, 4-7 open drain inputs
    ext_en <= 16'h00ff;
    ext_val <= 16'h00a5;
    bus_write(OFF_PIN_DATA, wd(16'ha0ff));
    bus_write(OFF_OPEN_DRAIN, wd(16'ha0f0));
    bus_write(OFF_DIRECTION, wd(16'hf000));
    repeat (4) @(posedge hclk);
    chk({16'h0000, pin_oe}, {16'h0000, 16'h5000}, "open drain enables");
    rchk(OFF_PIN_DATA, wd(16'hafa5), "pin levels");
    bus_write(OFF_OPEN_DRAIN, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    chk({16'h0000, pin_oe}, {16'h0000, 16'hf000}, "push pull enables");
    chk({16'h0000, pin_out & pin_oe}, {16'h0000, 16'ha000}, "driven data");
    rchk(OFF_PIN_DATA, wd(16'hafa5), "pin levels push pull");
    $display("output test done");
    // back to quiet inputs, then clear stale events
    bus_write(OFF_DIRECTION, 32'h0000_0000);
    bus_write(OFF_PIN_DATA, 32'h0000_0000);
    ext_en <= 16'hffff;
    ext_val <= 16'h0000;
    repeat (6) @(posedge hclk);
    bus_write(OFF_EVENTS, 32'hffff_ffff);
    rchk(OFF_EVENTS, 32'h0000_0000, "events cleared");
    // line 0 falling only, line 1 any change and unmasked
    bus_write(OFF_EDGE_SELECT, wd(16'h0001));
    bus_write(OFF_IRQ_MASK, wd(16'h0002));
    ext_val <= 16'h0003;
    repeat (5) @(posedge hclk);
    rchk(OFF_EVENTS, wd(16'h0002), "rising events");
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    ext_val <= 16'h0000;
    repeat (5) @(posedge hclk);
    rchk(OFF_EVENTS, wd(16'h0003), "falling events");
    bus_write(OFF_EVENTS, 32'h0000_ffff);
    rchk(OFF_EVENTS, wd(16'h0003), "zero write kept");
    bus_write(OFF_EVENTS, wd(16'h0002));
    rchk(OFF_EVENTS, wd(16'h0001), "one write clears");
    chk({31'h0, irq}, 32'h0, "irq masked line");
    bus_write(OFF_IRQ_MASK, wd(16'hffff));
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h1, "irq after unmask");
    bus_write(OFF_EVENTS, wd(16'hffff));
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    $display("event test done");
    // a change on an output line makes no event
    bus_write(OFF_PIN_DATA, wd(16'h0004));
    bus_write(OFF_DIRECTION, wd(16'h0004));
    repeat (6) @(posedge hclk);
    rchk(OFF_EVENTS, 32'h0000_0000, "output line quiet");
    chk({31'h0, irq}, 32'h0, "no irq from output");
    chk({31'h0, hresp}, 32'h0, "okay response");
    $display("output event test done");
    // reset again with every pin high: no false change after release
    ext_val <= 16'hffff;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    rchk(OFF_EVENTS, 32'h0000_0000, "no event after reset");
    rchk(OFF_DIRECTION, 32'h0000_0000, "direction after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("second reset test done");
    test_done();
  end
endmodule // test_gpio_port

`default_nettype wire
